// [adfs_diag.sv]
// Our own choices: the register addresses and the Wishbone interface to the registers.
module adfs_diag
   import adfs_pkg::*;
(
   // clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    reset_i,
   // register bus
   input  wire adfs_pkg::adfs_wb_req_t  wb_req_i,
   output      adfs_pkg::adfs_wb_rsp_t  wb_rsp_o,
   // analog comparator monitors
   input  wire adfs_pkg::adfs_mon_t     mon_i,
   // controls to the power stage
   output      logic                    hcl_sel_o,
   output      logic                    channels_off_o,
   output      logic                    outputs_tristate_o,
   output      logic                    outputs_midsupply_o,
   output      logic                    standby_o,
   // open-drain pins
   output      adfs_pkg::adfs_pin_t     clip_load_pin_o,
   output      adfs_pkg::adfs_pin_t     mute_clip_pin_o,
   output      adfs_pkg::adfs_pin_t     fault_pin_o
);
   import adfs_pkg::*;

   // ****************************************************************
   // helpers
   // ****************************************************************
   // picks one of four bits by a two-bit select
   function automatic logic pick4(input logic [3:0] v, input logic [1:0] s);
      pick4 = v[s];
   endfunction

   // ****************************************************************
   // synchroniser
   // ****************************************************************
   logic [ADFS_MON_W-1:0] sync1_r;
   logic [ADFS_MON_W-1:0] sync2_r;
   adfs_mon_t             mon;

   // two flops per bit; only sync2 is looked at by the logic
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
      end
      else
      begin
         sync1_r <= mon_i;
         sync2_r <= sync1_r;
      end
   end

   assign mon = adfs_mon_t'(sync2_r);

   // ****************************************************************
   // control registers
   // ****************************************************************
   logic [3:0] ctrl_one_r;
   logic [2:0] ctrl_three_r;
   logic [2:0] map_r;
   logic       ov_latch_r;
   logic       ack_r;
   logic [31:0] rdat_r;

   wire [7:0] adr_w     = wb_req_i.adr[7:0];
   wire       req_w     = wb_req_i.cyc & wb_req_i.stb & ~ack_r;
   wire       wr_w      = req_w & wb_req_i.we & wb_req_i.sel[0];
   wire       wr_c1_w   = wr_w & (adr_w == ADFS_OFF_CTRL_ONE);
   wire       wr_c3_w   = wr_w & (adr_w == ADFS_OFF_CTRL_THREE);
   wire       wr_map_w  = wr_w & (adr_w == ADFS_OFF_MAP);

   wire [1:0] clip_level_field_w    = ctrl_one_r[ADFS_CLIP_LEVEL_FIELD_LSB +: 2];
   wire [1:0] twlim_w   = ctrl_one_r[ADFS_TWLIM_LSB +: 2];
   wire       tw_sel_w  = ctrl_three_r[ADFS_TW_BIT];
   wire       lctm_w    = map_r[ADFS_LCTM_BIT];

   // ****************************************************************
   // live status decode
   // ****************************************************************
   logic [3:0] load_w;
   logic [3:0] clip_w;

   genvar ch;
   generate
      for (ch = 0; ch < 4; ch++)
      begin : g_ch
         // tweeter select picks the lower threshold comparator
         assign load_w[ch] = tw_sel_w ? mon.cur_tweet[ch]
                                      : mon.cur_short[ch];
         // clip level chooses which distortion comparator reports
         assign clip_w[ch] = pick4({mon.clip[12+ch], mon.clip[8+ch],
                                    mon.clip[4+ch], mon.clip[ch]}, clip_level_field_w);
      end
   endgenerate

   wire twarn_w = pick4(mon.temp_over[3:0], twlim_w);
   wire any_load_w = |load_w;
   wire any_clip_w = |clip_w;

   // ****************************************************************
   // thermal shutdown state machine
   // ****************************************************************
   adfs_th_t th_r;
   adfs_th_t th_nxt;

   // hysteresis: trip at 150, release only below 140
   always_comb
   begin
      th_nxt = th_r;
      case (th_r)
         ADFS_TH_RUN:
         begin
            if (mon.temp_over[ADFS_TEMP_150])
               th_nxt = ADFS_TH_SHDN;
         end
         ADFS_TH_SHDN:
         begin
            if (!mon.temp_over[ADFS_TEMP_140])
               th_nxt = ADFS_TH_RUN;
         end
         default:
            th_nxt = ADFS_TH_RUN;
      endcase
   end

   // ****************************************************************
   // pump undervoltage hysteresis
   // ****************************************************************
   logic pump_undervoltage_flag_r;
   logic pump_undervoltage_flag_nxt;

   // set below the low trip, held until the high trip is passed
   assign pump_undervoltage_flag_nxt = mon.pump_low ? 1'b1 : (mon.pump_ok ? 1'b0 : pump_undervoltage_flag_r);

   // ****************************************************************
   // control register writes
   // ****************************************************************
   // standby: overvoltage sets it and wins over a clearing write
   wire       standby_bit_wr_w  = wr_c3_w ? wb_req_i.dat[ADFS_STANDBY_BIT_BIT] : ctrl_three_r[ADFS_STANDBY_BIT_BIT];
   wire       standby_bit_nxt_w = mon.supply_high | standby_bit_wr_w;
   wire [2:0] c3_nxt_w   = wr_c3_w ? {standby_bit_nxt_w, wb_req_i.dat[1:0]}
                                   : {standby_bit_nxt_w, ctrl_three_r[1:0]};
   // the latch only drops once the host clears standby with the supply back
   wire       ov_nxt_w   = mon.supply_high |
                           (ov_latch_r & ~(wr_c3_w & ~wb_req_i.dat[ADFS_STANDBY_BIT_BIT]));

   // thermal shutdown leaves these untouched, so settings survive it
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ctrl_one_r   <= ADFS_RST_CTRL_ONE;
         ctrl_three_r <= ADFS_RST_CTRL_THREE;
         map_r        <= ADFS_RST_MAP;
         ov_latch_r   <= 1'b0;
      end
      else
      begin
         if (wr_c1_w)
            ctrl_one_r <= wb_req_i.dat[3:0];
         if (wr_map_w)
            map_r <= wb_req_i.dat[2:0];
         ctrl_three_r <= c3_nxt_w;
         ov_latch_r   <= ov_nxt_w;
      end
   end

   // ****************************************************************
   // register read mux
   // ****************************************************************
   wire [5:0] status_w = {ov_latch_r, ~mon.supply_high, ~mon.supply_low,
                          pump_undervoltage_flag_r, (th_r == ADFS_TH_SHDN), twarn_w};
   logic [31:0] rd_w;

   // unmapped addresses read zero but are still acknowledged
   always_comb
   begin
      case (adr_w)
         ADFS_OFF_CTRL_ONE:   rd_w = {28'h0000000, ctrl_one_r};
         ADFS_OFF_CTRL_THREE: rd_w = {29'h00000000, ctrl_three_r};
         ADFS_OFF_MAP:        rd_w = {29'h00000000, map_r};
         ADFS_OFF_OST_ZERO:   rd_w = {28'h0000000, clip_w};
         ADFS_OFF_OST_ONE:    rd_w = {28'h0000000, load_w};
         ADFS_OFF_OST_THREE:  rd_w = {28'h0000000, mon.offset_hi};
         ADFS_OFF_STATUS:     rd_w = {26'h0000000, status_w};
         default:             rd_w = 32'h00000000;
      endcase
   end

   // one wait state: ack the edge after the request is seen
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ack_r  <= 1'b0;
         rdat_r <= 32'h00000000;
      end
      else
      begin
         ack_r  <= req_w;
         rdat_r <= req_w ? rd_w : 32'h00000000;
      end
   end

   // ****************************************************************
   // status state and pin drive
   // ****************************************************************
   wire cl0_low_w  = (lctm_w & any_load_w) |
                     (map_r[ADFS_CLPEN0_BIT] & any_clip_w);
   wire cl1_low_w  = map_r[ADFS_CLPEN1_BIT] & any_clip_w;
   wire flt_low_w  = mon.supply_low | mon.supply_high;

   logic cl0_oe_n_r;
   logic cl1_oe_n_r;
   logic flt_oe_n_r;
   logic chan_off_r;
   logic tri_r;
   logic mid_r;

   // all live flags refresh every cycle; only mid_r, which follows the overvoltage latch, waits on the host
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         th_r       <= ADFS_TH_RUN;
         pump_undervoltage_flag_r     <= 1'b0;
         cl0_oe_n_r <= 1'b1;
         cl1_oe_n_r <= 1'b1;
         flt_oe_n_r <= 1'b1;
         chan_off_r <= 1'b0;
         tri_r      <= 1'b0;
         mid_r      <= 1'b0;
      end
      else
      begin
         th_r       <= th_nxt;
         pump_undervoltage_flag_r     <= pump_undervoltage_flag_nxt;
         cl0_oe_n_r <= ~cl0_low_w;
         cl1_oe_n_r <= ~cl1_low_w;
         flt_oe_n_r <= ~flt_low_w;
         chan_off_r <= (th_nxt == ADFS_TH_SHDN);
         tri_r      <= pump_undervoltage_flag_nxt | mon.supply_low;
         mid_r      <= ov_nxt_w;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // open-drain pins only ever pull low, so the data bit stays zero
   assign clip_load_pin_o     = '{out: 1'b0, oe_n: cl0_oe_n_r};
   assign mute_clip_pin_o     = '{out: 1'b0, oe_n: cl1_oe_n_r};
   assign fault_pin_o         = '{out: 1'b0, oe_n: flt_oe_n_r};
   assign wb_rsp_o            = '{ack: ack_r, dat: rdat_r};
   assign hcl_sel_o           = ctrl_three_r[ADFS_HCL_BIT];
   assign standby_o           = ctrl_three_r[ADFS_STANDBY_BIT_BIT];
   assign channels_off_o      = chan_off_r;
   assign outputs_tristate_o  = tri_r;
   assign outputs_midsupply_o = mid_r;

endmodule

// [adfs_pkg.sv]
package adfs_pkg;

   // ****************************************************************
   // register offsets (byte addresses, one word each)
   // ****************************************************************
   localparam logic [7:0] ADFS_OFF_CTRL_ONE   = 8'h00;
   localparam logic [7:0] ADFS_OFF_CTRL_THREE = 8'h04;
   localparam logic [7:0] ADFS_OFF_MAP        = 8'h08;
   localparam logic [7:0] ADFS_OFF_OST_ZERO   = 8'h0c;
   localparam logic [7:0] ADFS_OFF_OST_ONE    = 8'h10;
   localparam logic [7:0] ADFS_OFF_OST_THREE  = 8'h14;
   localparam logic [7:0] ADFS_OFF_STATUS     = 8'h18;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int ADFS_CLIP_LEVEL_FIELD_LSB   = 0;  // control_one [1:0] clip level
   localparam int ADFS_TWLIM_LSB  = 2;  // control_one [3:2] thermal warning limit
   localparam int ADFS_HCL_BIT    = 0;  // control_three
   localparam int ADFS_TW_BIT     = 1;  // control_three
   localparam int ADFS_STANDBY_BIT_BIT   = 2;  // control_three
   localparam int ADFS_LCTM_BIT   = 0;  // map
   localparam int ADFS_CLPEN0_BIT = 1;  // map: clip onto clip_load pin
   localparam int ADFS_CLPEN1_BIT = 2;  // map: clip onto mute_clip pin
   localparam int ADFS_ST_TWARN   = 0;  // status
   localparam int ADFS_ST_TSHDN   = 1;
   localparam int ADFS_ST_PUMP_UNDERVOLTAGE_FLAG    = 2;
   localparam int ADFS_ST_UV_N    = 3;
   localparam int ADFS_ST_OV_N    = 4;
   localparam int ADFS_ST_OVLAT   = 5;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [3:0] ADFS_RST_CTRL_ONE   = 4'h0;
   localparam logic [2:0] ADFS_RST_CTRL_THREE = 3'h5;  // hcl=1, tw=0, standby=1
   localparam logic [2:0] ADFS_RST_MAP        = 3'h0;

   // temperature comparator taps: 110,120,130,140,150 degrees
   localparam int ADFS_TEMP_140 = 3;
   localparam int ADFS_TEMP_150 = 4;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic [3:0]  cur_short;   // load current above short threshold
      logic [3:0]  cur_tweet;   // load current above tweeter threshold
      logic [15:0] clip;        // [level*4+ch] clipping at that level
      logic [3:0]  offset_hi;   // offset above threshold
      logic [4:0]  temp_over;   // junction above each tap
      logic        pump_low;    // hold voltage below 3.45 V
      logic        pump_ok;     // hold voltage above 3.75 V
      logic        supply_low;  // supply below 6 V
      logic        supply_high; // supply overvoltage
   } adfs_mon_t;

   localparam int ADFS_MON_W = $bits(adfs_mon_t);

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [31:0] adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } adfs_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } adfs_wb_rsp_t;

   typedef struct packed {
      logic out;
      logic oe_n;
   } adfs_pin_t;

   typedef enum logic [1:0] {
      ADFS_TH_RUN  = 2'b01,
      ADFS_TH_SHDN = 2'b10
   } adfs_th_t;

endpackage

// [adfs_host.sv]
module adfs_host
(
   // clock and bus
   input  wire logic                   clk_i,
   output      adfs_pkg::adfs_wb_req_t wb_req_o,
   input  wire adfs_pkg::adfs_wb_rsp_t wb_rsp_i
);
   timeunit 1ns;
   timeprecision 1ns;
   import adfs_pkg::*;
   adfs_wb_req_t req_r = '0;
   assign wb_req_o = req_r;
   // classic cycle: the request stands until ack is sampled, so no slave latency is assumed
   task automatic xfer(logic we, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      req_r <= '{1'b1, 1'b1, we, {24'h0, a}, 4'hf, d};
      @(posedge clk_i);
      while (wb_rsp_i.ack !== 1'b1)
         @(posedge clk_i);
      q = wb_rsp_i.dat;
      req_r <= '0;
   endtask
endmodule

// [adfs_diag_properties.sv]
module adfs_diag_properties
(
   // clock, reset and bus
   input wire logic                   clk_i,
   input wire logic                   reset_i,
   input wire adfs_pkg::adfs_wb_req_t wb_req_i,
   input wire adfs_pkg::adfs_wb_rsp_t wb_rsp_o,
   // monitors and outputs
   input wire adfs_pkg::adfs_mon_t    mon_i,
   input wire logic                   channels_off_o,
   input wire logic                   outputs_tristate_o,
   input wire logic                   outputs_midsupply_o,
   input wire logic                   standby_o,
   input wire adfs_pkg::adfs_pin_t    fault_pin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import adfs_pkg::*;
   logic [1:0] age_r;
   logic       warm;
   logic       clr;
   // $past of depth 3 means nothing until three edges clear of reset
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         age_r <= 2'h0;
      else if (!warm)
         age_r <= age_r + 2'h1;
   end
   // a taken write of control_three with standby low may release the latch
   assign warm = (age_r == 2'h3);
   assign clr = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !wb_rsp_o.ack
              && wb_req_i.adr[7:0] == ADFS_OFF_CTRL_THREE && !wb_req_i.dat[ADFS_STANDBY_BIT_BIT];
   // ****************************************************************
   // properties
   // ****************************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i || !warm);
   sequence s_take;
      wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
   endsequence
   sequence s_pulse;
      wb_rsp_o.ack ##1 !wb_rsp_o.ack;
   endsequence
   bus_answer_a: assert property (s_take |=> s_pulse)
      else $error("ack late or long");
   fault_pin_a: assert property (
      !fault_pin_o.oe_n == ($past(mon_i.supply_low, 3) || $past(mon_i.supply_high, 3)))
      else $error("fault pin wrong");
   outputs_tristate_a: assert property (
      $past(mon_i.pump_low, 3) || $past(mon_i.supply_low, 3) |-> outputs_tristate_o)
      else $error("outputs not tristated");
   shdn_enter_a: assert property ($past(mon_i.temp_over[4], 3) |-> channels_off_o)
      else $error("shutdown missed");
   shdn_leave_a: assert property (!$past(mon_i.temp_over[3], 3) |-> !channels_off_o)
      else $error("shutdown held");
   ov_cause_a: assert property ($rose(outputs_midsupply_o) |-> $past(mon_i.supply_high, 3))
      else $error("latch without cause");
   ov_latch_a: assert property (
      $past(mon_i.supply_high, 3) |-> outputs_midsupply_o ##[0:1] standby_o)
      else $error("overvoltage not latched");
   ov_hold_a: assert property (outputs_midsupply_o && !clr && !$past(clr) |=> outputs_midsupply_o)
      else $error("latch lost");
endmodule
bind adfs_diag adfs_diag_properties adfs_diag_properties_inst (.clk_i(clk_i), .reset_i(reset_i),
   .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .mon_i(mon_i), .channels_off_o(channels_off_o),
   .outputs_tristate_o(outputs_tristate_o), .outputs_midsupply_o(outputs_midsupply_o),
   .standby_o(standby_o), .fault_pin_o(fault_pin_o));

// [adfs_diag_tb.sv]
module adfs_diag_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import adfs_pkg::*;
   logic         clk_i, reset_i, hcl, choff, tri3, mid, standby_bit;
   adfs_mon_t    mon_r;
   adfs_wb_req_t wb_req;
   adfs_wb_rsp_t wb_rsp;
   adfs_pin_t    clp, mcp, flt;
   logic [31:0]  rd;
   int           fail_count, compares, seed, c, e, sh, uv;
   int           tseq[6] = '{5, 4, 3, 4, 5, 0};
   int           pseq[4] = '{2, 0, 1, 0};
   adfs_diag adfs_diag_inst (.clk_i(clk_i), .reset_i(reset_i), .wb_req_i(wb_req),
      .wb_rsp_o(wb_rsp), .mon_i(mon_r), .hcl_sel_o(hcl), .channels_off_o(choff),
      .outputs_tristate_o(tri3), .outputs_midsupply_o(mid), .standby_o(standby_bit),
      .clip_load_pin_o(clp), .mute_clip_pin_o(mcp), .fault_pin_o(flt));
   adfs_host adfs_host_inst (.clk_i(clk_i), .wb_req_o(wb_req), .wb_rsp_i(wb_rsp));
   // 50 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // ****************************************************************
   // checks and bus helpers
   // ****************************************************************
   task automatic chk_reg(string n, logic [31:0] x, logic [31:0] g);
      compares++;
      if (g !== x)
      begin
         $display("MISMATCH %s expected %h seen %h", n, x, g);
         fail_count++;
      end
   endtask
   task automatic chk_pin(string n, logic x, logic g);
      chk_reg(n, {31'h0, x}, {31'h0, g});
   endtask
   task automatic wr(logic [7:0] a, int d);
      adfs_host_inst.xfer(1'b1, a, d, rd);
   endtask
   task automatic rdc(logic [7:0] a, int x, string n);
      adfs_host_inst.xfer(1'b0, a, 32'h0, rd);
      chk_reg(n, x, rd);
   endtask
   // pins move on the third edge; the fourth lets that update land
   task automatic settle;
      repeat (4) @(posedge clk_i);
   endtask
   task automatic load_pass(int tw, int lctm);
      repeat (6)
      begin
         c = $random(seed);
         @(posedge clk_i);
         mon_r.cur_short <= c[3:0];
         mon_r.cur_tweet <= c[7:4] & (4'h1 << c[9:8]); // one output at a time
         e = tw ? c[7:4] & (1 << c[9:8]) : c[3:0];
         settle();
         rdc(ADFS_OFF_OST_ONE, e, "load");
         chk_pin("clip_load", !(lctm && e != 0), clp.oe_n);
      end
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // the tests need under 500 cycles; sixty times that means a hang
   initial
   begin
      #600000;
      fail_count++;
      results();
   end
   // ****************************************************************
   // tests
   // ****************************************************************
   initial
   begin
      seed = 53975;
      fail_count = 0;
      compares = 0;
      reset_i = 1'b1;
      mon_r = '0;
      mon_r.pump_ok = 1'b1;
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      rdc(ADFS_OFF_CTRL_ONE, 0, "control_one");
      rdc(ADFS_OFF_CTRL_THREE, 5, "control_three");
      rdc(ADFS_OFF_MAP, 0, "map");
      rdc(8'h1c, 0, "unmapped");
      $display("reset test done");
      wr(ADFS_OFF_CTRL_THREE, 4);
      chk_pin("hcl_sel", 1'b0, hcl);
      wr(ADFS_OFF_MAP, 1);
      wr(ADFS_OFF_CTRL_THREE, 0);
      wr(ADFS_OFF_CTRL_THREE, 2);
      load_pass(1, 1);
      wr(ADFS_OFF_MAP, 0);
      wr(ADFS_OFF_CTRL_THREE, 0);
      load_pass(0, 0);
      $display("load test done");
      wr(ADFS_OFF_MAP, 6);
      for (int lv = 0; lv < 4; lv++)
      begin
         wr(ADFS_OFF_CTRL_ONE, lv);
         c = $random(seed);
         @(posedge clk_i);
         mon_r.clip <= c[15:0];
         mon_r.offset_hi <= c[19:16];
         e = (c >> (lv * 4)) & 15;
         settle();
         rdc(ADFS_OFF_OST_ZERO, e, "clip");
         rdc(ADFS_OFF_OST_THREE, c[19:16], "offset");
         chk_pin("clip_load", e == 0, clp.oe_n);
         chk_pin("mute_clip", e == 0, mcp.oe_n);
      end
      $display("clip test done");
      sh = 0;
      for (int lim = 0; lim < 4; lim++)
      begin
         wr(ADFS_OFF_CTRL_ONE, lim << 2);
         foreach (tseq[i])
         begin
            @(posedge clk_i);
            mon_r.temp_over <= 5'((1 << tseq[i]) - 1);
            sh = tseq[i] >= 5 ? 1 : (tseq[i] < 4 ? 0 : sh);
            settle();
            rdc(ADFS_OFF_STATUS, 32'h18 | (tseq[i] > lim) | (sh << 1), "status");
            chk_pin("channels_off", sh[0], choff);
         end
      end
      uv = 0;
      foreach (pseq[i])
      begin
         @(posedge clk_i);
         mon_r.pump_low <= pseq[i][1];
         mon_r.pump_ok <= pseq[i][0];
         uv = pseq[i][1] ? 1 : (pseq[i][0] ? 0 : uv);
         settle();
         rdc(ADFS_OFF_STATUS, 32'h18 | (uv << 2), "status");
         chk_pin("tristate", uv[0], tri3);
      end
      $display("thermal and pump test done");
      @(posedge clk_i);
      mon_r.supply_low <= 1'b1;
      settle();
      rdc(ADFS_OFF_STATUS, 32'h10, "status");
      chk_pin("fault", 1'b0, flt.oe_n);
      chk_pin("tristate", 1'b1, tri3);
      @(posedge clk_i);
      mon_r.supply_low <= 1'b0;
      mon_r.supply_high <= 1'b1;
      settle();
      rdc(ADFS_OFF_STATUS, 32'h28, "status");
      rdc(ADFS_OFF_CTRL_THREE, 4, "control_three");
      chk_pin("midsupply", 1'b1, mid);
      chk_pin("fault", 1'b0, flt.oe_n);
      wr(ADFS_OFF_CTRL_THREE, 0); // still over the limit, so the latch holds
      rdc(ADFS_OFF_STATUS, 32'h28, "status");
      @(posedge clk_i);
      mon_r.supply_high <= 1'b0;
      settle();
      rdc(ADFS_OFF_STATUS, 32'h38, "status");
      wr(ADFS_OFF_CTRL_THREE, 0);
      rdc(ADFS_OFF_STATUS, 32'h18, "status");
      chk_pin("standby", 1'b0, standby_bit);
      chk_pin("midsupply", 1'b0, mid);
      chk_pin("fault", 1'b1, flt.oe_n);
      $display("supply test done");
      results();
   end
endmodule
